// file: verilog/qsb_bridge.sv
// Added by the designer: the placing of the registers and the APB register port.
`include "qsb_regs.svh"

module qsb_fifo #(
  parameter int W = 9,
  parameter int DEPTH = `QSB_OUT_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [AW:0] level
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire wr = in_valid && in_ready;
  wire rd = out_valid && out_ready;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : inc

  assign in_ready = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rp_q];
  assign level = cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) wp_q <= inc(wp_q);
      if (rd) rp_q <= inc(rp_q);
      cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr) mem[wp_q] <= in_data;
  end
endmodule : qsb_fifo

module qsb_bridge #(
  parameter int Q_DEPTH = `QSB_BUF_BYTES / 4,
  parameter int SAT_DEPTH = `QSB_SAT_DEPTH,
  parameter int TICK_CYCLES = `QSB_TICK_CYCLES,
  parameter int AGE_S = `QSB_AGE_S
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lan receive
  input wire logic lan_rx_valid,
  input wire qsb_pkg::qsb_beat_s lan_rx_beat,
  input wire qsb_pkg::qsb_hdr_s lan_rx_hdr,
  input wire logic [1:0] lan_rx_prio,
  output logic lan_rx_ready,
  // satellite burst transmit
  output logic sat_tx_valid,
  output qsb_pkg::qsb_beat_s sat_tx_beat,
  input wire logic sat_tx_ready,
  // satellite receive
  input wire logic sat_rx_valid,
  input wire qsb_pkg::qsb_beat_s sat_rx_beat,
  input wire qsb_pkg::qsb_hdr_s sat_rx_hdr,
  input wire logic sat_rx_fcs_bad,
  // lan transmit
  output logic lan_tx_valid,
  output qsb_pkg::qsb_beat_s lan_tx_beat,
  input wire logic lan_tx_ready,
  // management controller
  input wire logic mgmt_in_valid,
  input wire qsb_pkg::qsb_beat_s mgmt_in_beat,
  output logic mgmt_in_ready,
  output logic mgmt_out_valid,
  output qsb_pkg::qsb_beat_s mgmt_out_beat,
  input wire logic mgmt_out_ready,
  // flow control
  output logic fc_pause_req,
  output logic [15:0] fc_pause_quanta,
  output logic fc_backpressure
);
  localparam int QAW = $clog2(Q_DEPTH);
  localparam int SAW = $clog2(SAT_DEPTH);
  localparam int DBN = `QSB_DB_ENTRIES;
  localparam int QW = $bits(qsb_pkg::qsb_beat_s);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  function automatic logic [9:0] hash(input logic [47:0] m);
    hash = m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]};
  endfunction : hash

  // found flag in bit 2, lowest set index below
  function automatic logic [2:0] first1(input logic [3:0] v);
    first1 = v[0] ? 3'h4 : v[1] ? 3'h5 : v[2] ? 3'h6 : v[3] ? 3'h7 : 3'h0;
  endfunction : first1

  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `QSB_CRC_POLY) : (r >> 1);
    end
    crc_next = r;
  endfunction : crc_next

  // registers
  logic [4:0] ctrl_q;
  logic [15:0] pause_q;
  logic [47:0] mmac_q;
  wire wfq_en = ctrl_q[`QSB_CTRL_WFQ];
  wire chk_en = ctrl_q[`QSB_CTRL_CHK];
  wire fc_en = ctrl_q[`QSB_CTRL_FC];
  wire fdx_en = ctrl_q[`QSB_CTRL_FDX];
  wire inb_en = ctrl_q[`QSB_CTRL_INB];

  wire apb_wr = psel && penable && pwrite;
  wire sel_ctrl = paddr == `QSB_CTRL_OFS;
  wire sel_stat = paddr == `QSB_STAT_OFS;
  wire sel_pause = paddr == `QSB_PAUSE_OFS;
  wire sel_mlo = paddr == `QSB_MMAC_LO_OFS;
  wire sel_mhi = paddr == `QSB_MMAC_HI_OFS;
  wire sel_any = sel_ctrl || sel_stat || sel_pause || sel_mlo || sel_mhi;
  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] mlo_d = (mmac_q[31:0] & ~wmask) | (pwdata & wmask);
  wire [15:0] mhi_d = (mmac_q[47:32] & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
  wire [5:0] stat;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !sel_any;
  assign prdata = sel_ctrl ? {27'h000_0000, ctrl_q} :
                  sel_stat ? {26'h000_0000, stat} :
                  sel_pause ? {16'h0000, pause_q} :
                  sel_mlo ? mmac_q[31:0] :
                  sel_mhi ? {16'h0000, mmac_q[47:32]} : 32'h0000_0000;
  assign fc_pause_quanta = pause_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `QSB_CTRL_RST;
      pause_q <= `QSB_PAUSE_RST;
      mmac_q <= `QSB_MMAC_RST;
    end else if (apb_wr) begin
      if (sel_ctrl) ctrl_q <= (ctrl_q & ~wmask[4:0]) | (pwdata[4:0] & wmask[4:0]);
      if (sel_pause) pause_q <= (pause_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
      if (sel_mlo) mmac_q[31:0] <= mlo_d;
      if (sel_mhi) mmac_q[47:32] <= mhi_d;
    end
  end

  // aging time base, one second per step of now_q
  logic [31:0] tick_q;
  logic [15:0] now_q;
  logic [9:0] sweep_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_q <= '0;
      now_q <= '0;
      sweep_q <= '0;
    end else begin
      tick_q <= (tick_q == 32'(TICK_CYCLES - 1)) ? '0 : tick_q + 32'h0000_0001;
      if (tick_q == 32'(TICK_CYCLES - 1)) now_q <= now_q + 16'h0001;
      sweep_q <= sweep_q + 10'h001;
    end
  end

  // address database; hashed so every lookup is one cycle, no search
  logic [DBN-1:0] db_vld_q;
  qsb_pkg::qsb_db_s db_q [DBN];
  logic lan_sof_q;
  logic sat_sof_q;
  wire [9:0] lan_dst_ix = hash(lan_rx_hdr.dst);
  wire [9:0] lan_src_ix = hash(lan_rx_hdr.src);
  wire [9:0] sat_dst_ix = hash(sat_rx_hdr.dst);
  wire [9:0] sat_src_ix = hash(sat_rx_hdr.src);
  wire lan_hit = db_vld_q[lan_dst_ix] && db_q[lan_dst_ix].mac == lan_rx_hdr.dst;
  wire sat_hit = db_vld_q[sat_dst_ix] && db_q[sat_dst_ix].mac == sat_rx_hdr.dst;
  wire lan_local = lan_hit && db_q[lan_dst_ix].side == `QSB_SIDE_LAN;
  wire sat_remote = sat_hit && db_q[sat_dst_ix].side == `QSB_SIDE_SAT;
  wire lan_learn = lan_rx_valid && lan_rx_ready && lan_sof_q;
  wire sat_learn = sat_rx_valid && sat_sof_q;
  wire age_kill = db_vld_q[sweep_q] && (now_q - db_q[sweep_q].stamp) > 16'(AGE_S);

  // learning beats aging on the same entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      db_vld_q <= '0;
    end else begin
      if (age_kill) db_vld_q[sweep_q] <= 1'b0;
      if (lan_learn) db_vld_q[lan_src_ix] <= 1'b1;
      if (sat_learn) db_vld_q[sat_src_ix] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (lan_learn) db_q[lan_src_ix] <= {`QSB_SIDE_LAN, lan_rx_hdr.src, now_q};
    if (sat_learn) db_q[sat_src_ix] <= {`QSB_SIDE_SAT, sat_rx_hdr.src, now_q};
  end

  // lan and management ingress into the queues
  logic lan_drop_q;
  logic [1:0] lan_prio_q;
  logic mgmt_own_q;
  logic [3:0] q_in_valid;
  logic [3:0] q_in_ready;
  logic [3:0] q_out_valid;
  logic [3:0] q_out_ready;
  logic [3:0] q_near;
  qsb_pkg::qsb_beat_s q_out_beat [4];
  wire lan_drop = lan_sof_q ? lan_local : lan_drop_q;
  wire [1:0] lan_prio = lan_sof_q ? lan_rx_prio : lan_prio_q;
  wire qsb_pkg::qsb_beat_s q_in_beat = mgmt_own_q ? mgmt_in_beat : lan_rx_beat;
  wire mgmt_grab = lan_sof_q && !lan_rx_valid && mgmt_in_valid && inb_en && !mgmt_own_q;

  assign lan_rx_ready = !mgmt_own_q && (lan_drop || q_in_ready[lan_prio]);
  assign mgmt_in_ready = mgmt_own_q && inb_en && q_in_ready[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lan_sof_q <= 1'b1;
      lan_drop_q <= 1'b0;
      lan_prio_q <= 2'h0;
      mgmt_own_q <= 1'b0;
    end else begin
      if (lan_rx_valid && lan_rx_ready) begin
        lan_sof_q <= lan_rx_beat.last;
        lan_drop_q <= lan_drop;
        lan_prio_q <= lan_prio;
      end
      if (mgmt_grab) mgmt_own_q <= 1'b1;
      else if (mgmt_in_valid && mgmt_in_ready && mgmt_in_beat.last) mgmt_own_q <= 1'b0;
      else if (!inb_en && mgmt_own_q) mgmt_own_q <= 1'b0;
    end
  end

  // scheduler
  qsb_pkg::qsb_sched_e sch_q;
  logic [1:0] cur_q;
  logic out_in_ready;
  logic [3:0] elig;
  logic [3:0] cred_q [4];
  wire [2:0] f_ne = first1(q_out_valid);
  wire [2:0] f_el = first1(elig);
  wire reload = wfq_en && !f_el[2];
  wire [2:0] pick = (wfq_en && f_el[2]) ? f_el : f_ne;
  wire sch_idle = sch_q == qsb_pkg::SCH_IDLE;
  wire sch_start = sch_idle && pick[2];
  wire pop = sch_q == qsb_pkg::SCH_SEND && q_out_valid[cur_q] && out_in_ready;

  for (genvar i = 0; i < 4; i++) begin : g_q
    wire [3:0] wt = 4'(`QSB_WEIGHTS >> (4 * i));
    logic [QAW:0] lvl;
    assign q_in_valid[i] = mgmt_own_q ? (i == 0 && mgmt_in_valid && inb_en) :
                           (lan_rx_valid && !lan_drop && lan_prio == 2'(i));
    assign q_out_ready[i] = pop && cur_q == 2'(i);
    assign elig[i] = q_out_valid[i] && cred_q[i] != 4'h0;
    assign q_near[i] = lvl > (QAW+1)'(Q_DEPTH - `QSB_NEAR_MARGIN);
    qsb_fifo #(.W(QW), .DEPTH(Q_DEPTH)) u_q (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(q_in_valid[i]),
      .in_data(q_in_beat),
      .in_ready(q_in_ready[i]),
      .out_valid(q_out_valid[i]),
      .out_data(q_out_beat[i]),
      .out_ready(q_out_ready[i]),
      .level(lvl)
    );
    // credits refill only when no waiting queue has any left, so none starves
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cred_q[i] <= wt;
      end else if (sch_start && wfq_en) begin
        if (reload) cred_q[i] <= wt - 4'(pick[1:0] == 2'(i));
        else if (pick[1:0] == 2'(i)) cred_q[i] <= cred_q[i] - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sch_q <= qsb_pkg::SCH_IDLE;
      cur_q <= 2'h0;
    end else begin
      case (sch_q)
        qsb_pkg::SCH_IDLE: begin
          if (pick[2]) begin
            cur_q <= pick[1:0];
            sch_q <= qsb_pkg::SCH_SEND;
          end
        end
        qsb_pkg::SCH_SEND: begin
          if (pop && q_out_beat[cur_q].last) sch_q <= qsb_pkg::SCH_IDLE;
        end
        default: sch_q <= qsb_pkg::SCH_IDLE;
      endcase
    end
  end

  // small egress buffer absorbs modulator stalls
  qsb_fifo #(.W(QW), .DEPTH(`QSB_OUT_DEPTH)) u_out (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(sch_q == qsb_pkg::SCH_SEND && q_out_valid[cur_q]),
    .in_data(q_out_beat[cur_q]),
    .in_ready(out_in_ready),
    .out_valid(sat_tx_valid),
    .out_data(sat_tx_beat),
    .out_ready(sat_tx_ready),
    .level()
  );

  // flow control toward the terrestrial partner
  logic nf_q;
  logic pause_req_q;
  logic bp_q;
  wire near = |q_near;
  assign fc_pause_req = pause_req_q;
  assign fc_backpressure = bp_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nf_q <= 1'b0;
      pause_req_q <= 1'b0;
      bp_q <= 1'b0;
    end else begin
      nf_q <= near;
      pause_req_q <= fc_en && fdx_en && near && !nf_q;
      bp_q <= fc_en && !fdx_en && near;
    end
  end

  // satellite frame store; the verdict comes with the last beat, so
  // frames are written speculatively and committed or rolled back
  logic [9:0] sst [SAT_DEPTH];
  logic [SAW:0] swp_q;
  logic [SAW:0] cwp_q;
  logic [SAW:0] srp_q;
  logic s_keep_q;
  logic s_mg_q;
  logic s_ovf_q;
  wire s_keep = sat_sof_q ? !sat_remote : s_keep_q;
  wire s_mg = sat_sof_q ? (inb_en && sat_rx_hdr.dst == mmac_q) : s_mg_q;
  wire s_full = (swp_q - srp_q) == (SAW+1)'(SAT_DEPTH);
  wire s_ovf = (!sat_sof_q && s_ovf_q) || s_full;
  wire s_wr = sat_rx_valid && s_keep && !s_ovf;
  wire s_commit = s_wr && sat_rx_beat.last && !(chk_en && sat_rx_fcs_bad);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sat_sof_q <= 1'b1;
      s_keep_q <= 1'b0;
      s_mg_q <= 1'b0;
      s_ovf_q <= 1'b0;
      swp_q <= '0;
      cwp_q <= '0;
    end else if (sat_rx_valid) begin
      sat_sof_q <= sat_rx_beat.last;
      s_keep_q <= s_keep;
      s_mg_q <= s_mg;
      s_ovf_q <= s_ovf;
      if (s_commit) begin
        swp_q <= swp_q + 1'b1;
        cwp_q <= swp_q + 1'b1;
      end else if (sat_rx_beat.last) swp_q <= cwp_q;
      else if (s_wr) swp_q <= swp_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (s_wr) sst[swp_q[SAW-1:0]] <= {s_mg, sat_rx_beat.last, sat_rx_beat.data};
  end

  // lan transmit with fresh fcs; management frames bypass
  qsb_pkg::qsb_tx_e tx_q;
  logic [31:0] crc_q;
  logic [1:0] fcs_cnt_q;
  logic [SAW:0] srp_d;
  wire s_avail = srp_q != cwp_q;
  wire [9:0] s_beat = sst[srp_q[SAW-1:0]];
  wire tx_data = tx_q == qsb_pkg::TX_DATA;
  wire tx_fcs = tx_q == qsb_pkg::TX_FCS;
  wire [31:0] crc_inv = ~crc_q;
  wire lan_fire = lan_tx_valid && lan_tx_ready;
  wire s_pop = (mgmt_out_valid && mgmt_out_ready) || (tx_data && lan_fire);
  assign mgmt_out_valid = tx_data && s_avail && s_beat[9];
  assign mgmt_out_beat = s_beat[8:0];
  assign lan_tx_valid = tx_fcs || (s_avail && !s_beat[9]);
  assign lan_tx_beat = tx_fcs ? {fcs_cnt_q == 2'h3, crc_inv[8*fcs_cnt_q +: 8]} : {1'b0, s_beat[7:0]};
  assign srp_d = s_pop ? srp_q + 1'b1 : srp_q;
  assign stat = {s_avail, near, q_out_valid};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_q <= qsb_pkg::TX_DATA;
      crc_q <= `QSB_CRC_INIT;
      fcs_cnt_q <= 2'h0;
      srp_q <= '0;
    end else begin
      srp_q <= srp_d;
      case (tx_q)
        qsb_pkg::TX_DATA: begin
          if (lan_fire) begin
            crc_q <= crc_next(crc_q, s_beat[7:0]);
            if (s_beat[8]) tx_q <= qsb_pkg::TX_FCS;
          end
          fcs_cnt_q <= 2'h0;
        end
        qsb_pkg::TX_FCS: begin
          if (lan_fire) begin
            fcs_cnt_q <= fcs_cnt_q + 2'h1;
            if (fcs_cnt_q == 2'h3) begin
              tx_q <= qsb_pkg::TX_DATA;
              crc_q <= `QSB_CRC_INIT;
            end
          end
        end
        default: tx_q <= qsb_pkg::TX_DATA;
      endcase
    end
  end

  // checks
  sequence s_data_end;
    tx_data && lan_fire && s_beat[8];
  endsequence
  sequence s_fcs_start;
    tx_fcs && fcs_cnt_q == 2'h0;
  endsequence
  a_wfq_share: assert property (wfq_en && sch_start && !reload |=>
    cred_q[$past(pick[1:0])] == $past(cred_q[pick[1:0]]) - 4'h1) else $error("credit not spent");
  a_strict_top: assert property (!wfq_en && sch_idle && q_out_valid[0] |=> cur_q == 2'h0) else $error("q0 skipped");
  a_strict_preempt: assert property (!wfq_en && sch_idle && q_out_valid[1] && !q_out_valid[0] |=>
    cur_q == 2'h1 && sch_q == qsb_pkg::SCH_SEND) else $error("higher queue not next");
  a_frame_bound: assert property (sch_q == qsb_pkg::SCH_SEND && !(pop && q_out_beat[cur_q].last) |=>
    $stable(cur_q) && sch_q == qsb_pkg::SCH_SEND) else $error("queue switched mid frame");
  a_learn_src: assert property (lan_learn && !(sat_learn && sat_src_ix == lan_src_ix) |=>
    db_vld_q[$past(lan_src_ix)] && db_q[$past(lan_src_ix)].stamp == $past(now_q)) else $error("source not learned");
  a_age_out: assert property (age_kill && !(lan_learn && lan_src_ix == sweep_q) &&
    !(sat_learn && sat_src_ix == sweep_q) |=> !db_vld_q[$past(sweep_q)]) else $error("stale entry kept");
  a_local_drop: assert property (lan_rx_valid && lan_sof_q && lan_local && !mgmt_own_q |->
    q_in_valid == 4'h0) else $error("local frame queued");
  a_bad_drop: assert property (sat_rx_valid && sat_rx_beat.last && chk_en && sat_rx_fcs_bad |=>
    $stable(cwp_q) && swp_q == cwp_q) else $error("bad frame committed");
  a_fcs_tail: assert property (s_data_end |=> s_fcs_start) else $error("fcs not appended");
  a_pause_req: assert property (fc_en && fdx_en && near && !nf_q |=> fc_pause_req ##1 !fc_pause_req)
    else $error("pause not sent once");
  a_back_press: assert property (fc_en && !fdx_en && near |=> fc_backpressure) else $error("no backpressure");
  a_inband_off: assert property (!inb_en |-> !mgmt_in_ready && q_in_valid[0] == (!mgmt_own_q &&
    lan_rx_valid && !lan_drop && lan_prio == 2'h0)) else $error("management path open");
endmodule : qsb_bridge

// file: pkg/qsb_regs.svh
`ifndef QSB_REGS_SVH
`define QSB_REGS_SVH
// register byte offsets
`define QSB_CTRL_OFS 12'h000
`define QSB_STAT_OFS 12'h004
`define QSB_PAUSE_OFS 12'h008
`define QSB_MMAC_LO_OFS 12'h00C
`define QSB_MMAC_HI_OFS 12'h010
// control field positions
`define QSB_CTRL_WFQ 0
`define QSB_CTRL_CHK 1
`define QSB_CTRL_FC 2
`define QSB_CTRL_FDX 3
`define QSB_CTRL_INB 4
// reset values
`define QSB_CTRL_RST 5'h0F
`define QSB_PAUSE_RST 16'hFFFF
`define QSB_MMAC_RST 48'h0000_0000_0000
`define QSB_CRC_INIT 32'hFFFF_FFFF
`define QSB_CRC_POLY 32'hEDB8_8320
// queue weights, nibble i is queue i, queue 0 highest
`define QSB_WEIGHTS 16'h1248
`define QSB_SIDE_LAN 1'b0
`define QSB_SIDE_SAT 1'b1
// sizes
`define QSB_BUF_BYTES (120 * 1024)
`define QSB_DB_ENTRIES 1024
`define QSB_OUT_DEPTH 16
`define QSB_SAT_DEPTH 2048
`define QSB_NEAR_MARGIN 2048
// timing
`define QSB_CLK_HZ 25000000
`define QSB_TICK_S 1
`define QSB_TICK_CYCLES (`QSB_CLK_HZ * `QSB_TICK_S)
`define QSB_AGE_MIN 5
`define QSB_AGE_S (`QSB_AGE_MIN * 60)
`endif

// file: pkg/qsb_pkg.sv
package qsb_pkg;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } qsb_beat_s;
  typedef struct packed {
    logic [47:0] dst;
    logic [47:0] src;
  } qsb_hdr_s;
  typedef struct packed {
    logic side;
    logic [47:0] mac;
    logic [15:0] stamp;
  } qsb_db_s;
  typedef enum logic [1:0] {SCH_IDLE = 2'h1, SCH_SEND = 2'h2} qsb_sched_e;
  typedef enum logic [1:0] {TX_DATA = 2'h1, TX_FCS = 2'h2} qsb_tx_e;
endpackage : qsb_pkg

// file: bench/qsb_sink.sv
module qsb_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // stream from the block
  input wire logic valid,
  input wire qsb_pkg::qsb_beat_s beat,
  output logic ready,
  // slow mode and logs
  input wire logic stall,
  output int nf,
  output int nb,
  output logic [7:0] fb [32],
  output logic [7:0] lb [256]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic first_q;
  // slow mode backs the scheduler up mid-frame
  assign ready = !stall;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nf <= 0;
      nb <= 0;
      first_q <= 1'h1;
    end else if (valid && ready) begin
      lb[nb[7:0]] <= beat.data;
      nb <= nb + 1;
      if (first_q) begin
        fb[nf[4:0]] <= beat.data;
      end
      first_q <= beat.last;
      nf <= nf + 32'(beat.last);
    end
  end
endmodule : qsb_sink

// file: bench/qsb_bridge_tb_top.sv
`include "qsb_regs.svh"
module qsb_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] DST = 48'h0200_0000_00AA, SL = 48'h0200_0000_0001, SS = 48'h0400_0000_0001;
  localparam logic [47:0] S3 = 48'h0400_0000_0003, MG = 48'h0000_0000_0077;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, stall = 0, lan_stall = 0;
  logic mgmt_in_valid = 0, mgmt_out_ready = 1, mgmt_in_ready;
  logic [3:0] pstrb = 4'hF;
  qsb_pkg::qsb_beat_s mgmt_in_beat = '0;
  logic lan_rx_valid = 0, sat_rx_valid = 0, sat_rx_bad = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] lan_rx_prio = '0;
  qsb_pkg::qsb_beat_s lan_rx_beat = '0, sat_rx_beat = '0, sat_tx_beat, lan_tx_beat, mgmt_out_beat;
  qsb_pkg::qsb_hdr_s lan_rx_hdr = '0, sat_rx_hdr = '0;
  logic pready, pslverr, err, lan_rx_ready, sat_tx_valid, sat_tx_ready, lan_tx_valid, lan_tx_ready;
  logic mgmt_out_valid, fc_pause_req, fc_backpressure;
  logic [15:0] fc_pause_quanta;
  int sat_nf, lan_nb, n0, pc, n_mg = 0, n_pause = 0, n_fail = 0, tests_run = 0;
  logic [7:0] sat_fb [32];
  logic [7:0] lan_lb [256];
  logic [31:0] rst_val [5] = '{32'h0000_000F, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] wexp [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 8'h10, 8'h11, 8'h12, 8'h13, 8, 9, 8'h14};
  logic [7:0] sexp [4] = '{8'h30, 8'h00, 8'h10, 8'h20};
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    n_mg <= n_mg + int'(mgmt_out_valid === 1'h1 && mgmt_out_ready === 1'h1 && mgmt_out_beat.last === 1'h1);
    n_pause <= n_pause + int'(fc_pause_req === 1'h1);
  end
  // short aging and a queue deep enough for the near-full margin
  qsb_bridge #(.Q_DEPTH(4096), .TICK_CYCLES(10), .AGE_S(3)) uut (.sys_clk, .rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .lan_rx_valid, .lan_rx_beat, .lan_rx_hdr,
    .lan_rx_prio, .lan_rx_ready, .sat_tx_valid, .sat_tx_beat, .sat_tx_ready, .sat_rx_valid, .sat_rx_beat,
    .sat_rx_hdr, .sat_rx_fcs_bad(sat_rx_bad), .lan_tx_valid, .lan_tx_beat, .lan_tx_ready,
    .mgmt_in_valid, .mgmt_in_beat, .mgmt_in_ready, .mgmt_out_valid, .mgmt_out_beat,
    .mgmt_out_ready, .fc_pause_req, .fc_pause_quanta, .fc_backpressure);
  qsb_sink u_sat (.sys_clk, .rst, .valid(sat_tx_valid), .beat(sat_tx_beat), .ready(sat_tx_ready),
    .stall, .nf(sat_nf), .nb(), .fb(sat_fb), .lb());
  qsb_sink u_lan (.sys_clk, .rst, .valid(lan_tx_valid), .beat(lan_tx_beat), .ready(lan_tx_ready),
    .stall(lan_stall), .nf(), .nb(lan_nb), .fb(), .lb(lan_lb));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb
  task automatic lan_send(input logic [1:0] p, input logic [47:0] d, input logic [7:0] id, input int len);
    for (int i = 0; i < len; i++) begin
      lan_rx_valid <= 1'h1;
      lan_rx_prio <= p;
      lan_rx_hdr <= {d, SL};
      lan_rx_beat <= {1'(i == len - 1), i == 0 ? id : 8'(i)};
      do @(posedge sys_clk); while (lan_rx_ready !== 1'h1);
    end
    lan_rx_valid <= 1'h0;
    @(posedge sys_clk);
  endtask : lan_send
  // satellite side never stalls, so beats go one per cycle
  task automatic sat_send(input logic [47:0] d, input logic [47:0] s, input logic bad);
    for (int i = 0; i < 4; i++) begin
      sat_rx_valid <= 1'h1;
      sat_rx_bad <= bad;
      sat_rx_hdr <= {d, s};
      sat_rx_beat <= {1'(i == 3), 8'h40 + 8'(i)};
      @(posedge sys_clk);
    end
    sat_rx_valid <= 1'h0;
    @(posedge sys_clk);
  endtask : sat_send
  function automatic logic [31:0] fcs();
    logic [31:0] c;
    c = `QSB_CRC_INIT;
    for (int i = 0; i < 4; i++) begin
      c = c ^ {24'h00_0000, 8'h40 + 8'(i)};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ `QSB_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : fcs
  task automatic lan_check(input int n);
    repeat (40) @(posedge sys_clk);
    chk("lan bytes", n0 + n, lan_nb);
    chk("lan fcs", fcs(), {lan_lb[8'(lan_nb - 1)], lan_lb[8'(lan_nb - 2)], lan_lb[8'(lan_nb - 3)], lan_lb[8'(lan_nb - 4)]});
  endtask : lan_check
  task automatic wait_nf(input int n);
    for (int t = 0; t < 6000 && sat_nf < n; t++) @(posedge sys_clk);
    if (sat_nf < n) n_fail++;
  endtask : wait_nf
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 12'(i * 4), 32'h0000_0000);
      chk("reg reset", rst_val[i], rd);
    end
    apb(1'h0, 12'h0FC, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, 32'(err));
    apb(1'h1, `QSB_PAUSE_OFS, 32'h0000_1234);
    chk("pause quanta", 32'h0000_1234, 32'(fc_pause_quanta));
    // weighted mode is the reset mode; ten top frames, five next
    stall <= 1'h1;
    for (int i = 0; i < 15; i++) lan_send(i < 10 ? 2'h0 : 2'h1, DST, 8'(i < 10 ? i : i + 6), 20);
    stall <= 1'h0;
    wait_nf(15);
    for (int k = 0; k < 15; k++) chk("weighted order", 32'(wexp[k]), 32'(sat_fb[k]));
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0002);
    stall <= 1'h1;
    for (int q = 3; q >= 0; q--) lan_send(2'(q), DST, 8'((q & 3) * 16), 20);
    stall <= 1'h0;
    wait_nf(19);
    for (int k = 0; k < 4; k++) chk("strict order", 32'(sexp[k]), 32'(sat_fb[15 + k]));
    lan_send(2'h0, DST, 8'h50, 4);
    lan_send(2'h0, SL, 8'h51, 4);
    repeat (60) @(posedge sys_clk);
    chk("local filter", 32'd20, 32'(sat_nf));
    n0 = lan_nb;
    sat_send(DST, SS, 1'h0);
    sat_send(SS, S3, 1'h0);
    sat_send(DST, S3, 1'h1);
    lan_check(8);
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0000);
    lan_stall <= 1'h1;
    sat_send(DST, S3, 1'h1);
    repeat (8) @(posedge sys_clk);
    chk("lan held", n0 + 8, lan_nb);
    lan_stall <= 1'h0;
    lan_check(16);
    repeat (1200) @(posedge sys_clk);
    sat_send(SS, S3, 1'h0);
    lan_check(24);
    pstrb <= 4'h1;
    apb(1'h1, `QSB_MMAC_LO_OFS, 32'hFFFF_FF77);
    pstrb <= 4'hF;
    apb(1'h0, `QSB_MMAC_LO_OFS, 32'h0000_0000);
    chk("mmac strobe", 32'h0000_0077, rd);
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0010);
    mgmt_out_ready <= 1'h0;
    sat_send(MG, S3, 1'h0);
    repeat (10) @(posedge sys_clk);
    chk("mgmt held", 32'd1, 32'(mgmt_out_valid));
    mgmt_out_ready <= 1'h1;
    lan_check(24);
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0000);
    sat_send(MG, S3, 1'h0);
    lan_check(32);
    chk("mgmt frames", 32'd1, 32'(n_mg));
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_000C);
    stall <= 1'h1;
    pc = n_pause;
    lan_send(2'h3, DST, 8'h60, 2100);
    repeat (5) @(posedge sys_clk);
    chk("pause pulses", 32'(pc + 1), 32'(n_pause));
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0004);
    repeat (3) @(posedge sys_clk);
    chk("backpressure", 32'd1, 32'(fc_backpressure));
    stall <= 1'h0;
    wait_nf(21);
    chk("flow frame", 32'h0000_0060, 32'(sat_fb[20]));
    mgmt_in_valid <= 1'h1;
    mgmt_in_beat <= {1'h1, 8'h70};
    repeat (4) @(posedge sys_clk);
    chk("mgmt in closed", 32'd0, 32'(mgmt_in_ready));
    apb(1'h1, `QSB_CTRL_OFS, 32'h0000_0010);
    do @(posedge sys_clk); while (mgmt_in_ready !== 1'h1);
    mgmt_in_valid <= 1'h0;
    wait_nf(22);
    chk("mgmt in frame", 32'h0000_0070, 32'(sat_fb[21]));
    summarize();
  end
endmodule : qsb_bridge_tb_top
